//--- rtl/efa_pkg.sv
// Purpose: shared constants and types for the nonvolatile access controller
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   offsets are byte addresses inside the block window
package efa_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_DAT_LO = 8'h00;
    localparam logic [7:0] OFF_ADR_LO = 8'h04;
    localparam logic [7:0] OFF_DAT_HI = 8'h08;
    localparam logic [7:0] OFF_ADR_HI = 8'h0C;
    localparam logic [7:0] OFF_CTL    = 8'h10;
    localparam logic [7:0] OFF_UNLOCK = 8'h14;
    localparam logic [7:0] OFF_PFLAG  = 8'h18;

    // memory_access_control bit positions
    localparam int CTL_SPACE  = 7;
    localparam int CTL_ABORT  = 3;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_WR     = 1;
    localparam int CTL_RD     = 0;
    // peripheral_flag_register bit position of update_done_flag
    localparam int PFLAG_DONE = 7;

    // implemented widths of the high bytes
    localparam int DAT_HI_W = 6;
    localparam int ADR_HI_W = 5;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic [7:0] EE_ERASED   = 8'hFF;

    localparam int EE_DEPTH = 256;
    localparam int FL_WORDS = 8192;
    localparam int FL_AW    = 13;
    localparam int FL_DW    = 14;

    // self-timed write: erase half, program half
    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_TIME_NS = 4000000;
    localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;

    // synchroniser lanes
    localparam int SYN_N    = 4;
    localparam int SYN_PROT = 0;
    localparam int SYN_EXT  = 1;
    localparam int SYN_WDT  = 2;
    localparam int SYN_BOR  = 3;

    typedef enum logic [1:0] {WR_IDLE, WR_ERASE, WR_PROG} efa_wr_e;
    typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} efa_unlock_e;
endpackage : efa_pkg

//--- rtl/efa_nvm_store.sv
// Purpose: data EEPROM byte array and program flash word array
// Assumes: asynchronous read, synchronous write
// Notes:   no reset on the arrays; contents are nonvolatile by intent
`timescale 1ns/10ps
module efa_nvm_store #(
    parameter int EE_DEPTH = efa_pkg::EE_DEPTH,
    parameter int FL_WORDS = efa_pkg::FL_WORDS
) (
    input  wire logic                     clk,      // core clock
    input  wire logic                     ee_we,    // eeprom write strobe
    input  wire logic [7:0]               ee_waddr, // eeprom write address
    input  wire logic [7:0]               ee_wdata, // eeprom write byte
    input  wire logic [7:0]               ee_raddr, // core eeprom read address
    output logic      [7:0]               ee_rdata, // core eeprom read byte
    input  wire logic [7:0]               ee_paddr, // programmer eeprom address
    output logic      [7:0]               ee_pdata, // programmer eeprom byte
    input  wire logic                     fl_we,    // flash load strobe
    input  wire logic [efa_pkg::FL_AW-1:0] fl_paddr, // programmer flash address
    input  wire logic [efa_pkg::FL_DW-1:0] fl_wdata, // flash load word
    output logic      [efa_pkg::FL_DW-1:0] fl_pdata, // programmer flash word
    input  wire logic [efa_pkg::FL_AW-1:0] fl_raddr, // core flash address
    output logic      [efa_pkg::FL_DW-1:0] fl_rdata  // core flash word
);
    localparam int FAW = $clog2(FL_WORDS);
    localparam int EAW = $clog2(EE_DEPTH);

    logic [7:0]               ee_mem [EE_DEPTH];
    logic [efa_pkg::FL_DW-1:0] fl_mem [FL_WORDS];

    // a 4K part simply ignores the top address bit
    always_ff @(posedge clk) begin
        if (ee_we) begin
            ee_mem[ee_waddr[EAW-1:0]] <= ee_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (fl_we) begin
            fl_mem[fl_paddr[FAW-1:0]] <= fl_wdata;
        end
    end

    assign ee_rdata = ee_mem[ee_raddr[EAW-1:0]];
    assign ee_pdata = ee_mem[ee_paddr[EAW-1:0]];
    assign fl_rdata = fl_mem[fl_raddr[FAW-1:0]];
    assign fl_pdata = fl_mem[fl_paddr[FAW-1:0]];
endmodule : efa_nvm_store

//--- rtl/efa_ctrl.sv
// Purpose: indirect access controller for data EEPROM and program flash
// Assumes: AHB-Lite slave, single word transfers, 25 MHz hclk
// Notes:   reset requests from pins act as synchronous resets of this block
`timescale 1ns/10ps
module efa_ctrl #(
    parameter int WRITE_CYCLES = efa_pkg::WRITE_CYCLES,
    parameter int FL_WORDS     = efa_pkg::FL_WORDS
) (
    input  wire logic        hclk,          // core clock
    input  wire logic        hresetn,       // power-on reset, low
    input  wire logic        hsel,          // slave select
    input  wire logic [31:0] haddr,         // byte address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write not read
    input  wire logic [2:0]  hsize,         // word only
    input  wire logic        hready,        // bus ready
    input  wire logic [31:0] hwdata,        // write data
    output logic      [31:0] hrdata,        // read data
    output logic             hreadyout,     // slave ready
    output logic             hresp,         // always okay
    input  wire logic        code_protect,  // protect fuse level
    input  wire logic        ext_reset_req, // external reset pin level
    input  wire logic        wdt_reset_req, // watchdog reset level
    input  wire logic        bor_req,       // brown-out reset level
    input  wire logic        pgm_req,       // programmer access
    input  wire logic        pgm_we,        // programmer flash load
    input  wire logic        pgm_space,     // 1 flash, 0 eeprom
    input  wire logic [12:0] pgm_addr,      // programmer address
    input  wire logic [13:0] pgm_wdata,     // programmer load word
    output logic      [13:0] pgm_rdata,     // programmer read word
    output logic             pgm_refused    // access refused
);
    localparam logic [31:0] ERASE_LD = 32'(WRITE_CYCLES / 2 - 1);
    localparam logic [31:0] PROG_LD  = 32'(WRITE_CYCLES - WRITE_CYCLES / 2 - 1);

    logic [efa_pkg::SYN_N-1:0] sync1_q;
    logic [efa_pkg::SYN_N-1:0] sync2_q;
    logic [efa_pkg::SYN_N-1:0] raw_in;
    logic                      sreset;
    logic                      prot;

    logic        ap_we_q;
    logic        ap_rd_q;
    logic [7:0]  ap_off_q;
    logic        ready_q;
    logic [31:0] rdata_q;
    logic [7:0]  wdat;
    logic [7:0]  rd_mux;
    logic        ctl_we;

    logic [7:0]  dat_lo_q;
    logic [7:0]  adr_lo_q;
    logic [5:0]  dat_hi_q;
    logic [4:0]  adr_hi_q;
    logic        space_q;
    logic        permit_q;
    logic        abort_q;
    logic        done_q;
    logic        rd_q;
    logic        rd_stage_q;
    logic        rd_latch;

    efa_pkg::efa_wr_e     st_q;
    efa_pkg::efa_unlock_e ul_q;
    logic [31:0] tmr_q;
    logic [7:0]  wr_adr_q;
    logic [7:0]  wr_dat_q;
    logic        wr_busy;
    logic        wr_go;
    logic        wr_end;
    logic        ee_we;

    logic [7:0]  ee_rdata;
    logic [7:0]  ee_pdata;
    logic [13:0] fl_rdata;
    logic [13:0] fl_pdata;
    logic [13:0] pgm_rdata_q;
    logic        pgm_refused_q;

    // pin levels pass two flops before use
    assign raw_in = {bor_req, wdt_reset_req, ext_reset_req, code_protect};
    for (genvar i = 0; i < efa_pkg::SYN_N; i++) begin : g_sync
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
            end else begin
                sync1_q[i] <= raw_in[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end
    assign sreset = sync2_q[efa_pkg::SYN_EXT] | sync2_q[efa_pkg::SYN_WDT]
                  | sync2_q[efa_pkg::SYN_BOR];
    assign prot   = sync2_q[efa_pkg::SYN_PROT];

    // bus: writes take no wait state, reads take one so hrdata is registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_we_q  <= 1'b0;
            ap_rd_q  <= 1'b0;
            ap_off_q <= 8'h00;
            ready_q  <= 1'b1;
        end else begin
            ap_we_q <= hsel & htrans[1] & hready & hwrite;
            ap_rd_q <= hsel & htrans[1] & hready & ~hwrite;
            ready_q <= ~(hsel & htrans[1] & hready & ~hwrite);
            if (hsel & htrans[1] & hready) begin
                ap_off_q <= haddr[7:0];
            end
        end
    end

    assign wdat   = hwdata[7:0];
    assign ctl_we = ap_we_q && ap_off_q == efa_pkg::OFF_CTL;

    always_comb begin
        unique case (ap_off_q)
            efa_pkg::OFF_DAT_LO: rd_mux = dat_lo_q;
            efa_pkg::OFF_ADR_LO: rd_mux = adr_lo_q;
            efa_pkg::OFF_DAT_HI: rd_mux = {2'b00, dat_hi_q};
            efa_pkg::OFF_ADR_HI: rd_mux = {3'b000, adr_hi_q};
            efa_pkg::OFF_CTL:    rd_mux = {space_q, 3'b000, abort_q, permit_q,
                                           wr_busy, rd_q};
            efa_pkg::OFF_PFLAG:  rd_mux = {done_q, 7'h00};
            default:             rd_mux = 8'h00; // unlock port reads zero
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (ap_rd_q) begin
            rdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // unlock sequence: any other register write disarms it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ul_q <= efa_pkg::UL_IDLE;
        end else if (sreset) begin
            ul_q <= efa_pkg::UL_IDLE;
        end else if (ap_we_q) begin
            if (ap_off_q != efa_pkg::OFF_UNLOCK) begin
                ul_q <= efa_pkg::UL_IDLE;
            end else if (wdat == efa_pkg::UNLOCK_KEY1) begin
                ul_q <= efa_pkg::UL_KEY1;
            end else if (ul_q == efa_pkg::UL_KEY1 && wdat == efa_pkg::UNLOCK_KEY2) begin
                ul_q <= efa_pkg::UL_ARMED;
            end else begin
                ul_q <= efa_pkg::UL_IDLE;
            end
        end
    end

    // address and data bytes; a hardware read load beats a bus write
    assign rd_latch = rd_q & (~space_q | rd_stage_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dat_lo_q <= 8'h00;
            adr_lo_q <= 8'h00;
            dat_hi_q <= 6'h00;
            adr_hi_q <= 5'h00;
        end else if (sreset) begin
            dat_lo_q <= 8'h00;
            adr_lo_q <= 8'h00;
            dat_hi_q <= 6'h00;
            adr_hi_q <= 5'h00;
        end else begin
            if (rd_latch) begin
                dat_lo_q <= space_q ? fl_rdata[7:0] : ee_rdata;
                if (space_q) begin
                    dat_hi_q <= fl_rdata[13:8];
                end
            end else if (ap_we_q && ap_off_q == efa_pkg::OFF_DAT_LO) begin
                dat_lo_q <= wdat;
            end else if (ap_we_q && ap_off_q == efa_pkg::OFF_DAT_HI) begin
                dat_hi_q <= wdat[5:0];
            end
            if (ap_we_q && ap_off_q == efa_pkg::OFF_ADR_LO) begin
                adr_lo_q <= wdat;
            end
            if (ap_we_q && ap_off_q == efa_pkg::OFF_ADR_HI) begin
                adr_hi_q <= wdat[4:0];
            end
        end
    end

    // space and permit bits, cleared by every reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            space_q  <= 1'b0;
            permit_q <= 1'b0;
        end else if (sreset) begin
            space_q  <= 1'b0;
            permit_q <= 1'b0;
        end else if (ctl_we) begin
            space_q  <= wdat[efa_pkg::CTL_SPACE];
            permit_q <= wdat[efa_pkg::CTL_PERMIT];
        end
    end

    // read start: set-only, one cycle for eeprom, two for flash
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q       <= 1'b0;
            rd_stage_q <= 1'b0;
        end else if (sreset) begin
            rd_q       <= 1'b0;
            rd_stage_q <= 1'b0;
        end else if (rd_q) begin
            rd_q       <= ~rd_latch;
            rd_stage_q <= ~rd_latch;
        end else if (ctl_we && wdat[efa_pkg::CTL_RD] && !wr_busy) begin
            rd_q <= 1'b1;
        end
    end

    // self-timed write: erase phase then program phase
    assign wr_busy = st_q != efa_pkg::WR_IDLE;
    assign wr_go   = ctl_we && wdat[efa_pkg::CTL_WR] && !wdat[efa_pkg::CTL_SPACE]
                  && permit_q
                  && ul_q == efa_pkg::UL_ARMED
                  && !wr_busy && !rd_q;
    assign wr_end  = st_q == efa_pkg::WR_PROG && tmr_q == 32'h0000_0000;
    assign ee_we   = wr_busy && tmr_q == 32'h0000_0000 && !sreset;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q     <= efa_pkg::WR_IDLE;
            tmr_q    <= 32'h0000_0000;
            wr_adr_q <= 8'h00;
            wr_dat_q <= 8'h00;
        end else if (sreset) begin
            st_q  <= efa_pkg::WR_IDLE;
            tmr_q <= 32'h0000_0000;
        end else begin
            unique case (st_q)
                efa_pkg::WR_IDLE: begin
                    if (wr_go) begin
                        st_q     <= efa_pkg::WR_ERASE;
                        tmr_q    <= ERASE_LD;
                        wr_adr_q <= adr_lo_q;
                        wr_dat_q <= dat_lo_q;
                    end
                end
                efa_pkg::WR_ERASE: begin
                    if (tmr_q == 32'h0000_0000) begin
                        st_q  <= efa_pkg::WR_PROG;
                        tmr_q <= PROG_LD;
                    end else begin
                        tmr_q <= tmr_q - 32'h0000_0001;
                    end
                end
                efa_pkg::WR_PROG: begin
                    if (tmr_q == 32'h0000_0000) begin
                        st_q <= efa_pkg::WR_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 32'h0000_0001;
                    end
                end
                default: st_q <= efa_pkg::WR_IDLE;
            endcase
        end
    end

    // abort flag survives the pin resets so software can see it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            abort_q <= 1'b0;
        end else if (sreset && wr_busy) begin
            abort_q <= 1'b1;
        end else if (wr_end) begin
            abort_q <= 1'b0;
        end else if (ctl_we) begin
            abort_q <= wdat[efa_pkg::CTL_ABORT];
        end
    end

    // completion beats a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_q <= 1'b0;
        end else if (sreset) begin
            done_q <= 1'b0;
        end else if (wr_end) begin
            done_q <= 1'b1;
        end else if (ap_we_q && ap_off_q == efa_pkg::OFF_PFLAG) begin
            done_q <= wdat[efa_pkg::PFLAG_DONE];
        end
    end

    // programmer port: shut out while protected, core keeps full access
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgm_rdata_q   <= 14'h0000;
            pgm_refused_q <= 1'b0;
        end else begin
            pgm_refused_q <= pgm_req & prot;
            if (pgm_req && !prot) begin
                pgm_rdata_q <= pgm_space ? fl_pdata : {6'h00, ee_pdata};
            end else begin
                pgm_rdata_q <= 14'h0000;
            end
        end
    end

    efa_nvm_store #(
        .EE_DEPTH (efa_pkg::EE_DEPTH),
        .FL_WORDS (FL_WORDS)
    ) u_store (
        .clk      (hclk),
        .ee_we    (ee_we),
        .ee_waddr (wr_adr_q),
        .ee_wdata (st_q == efa_pkg::WR_ERASE ? efa_pkg::EE_ERASED : wr_dat_q),
        .ee_raddr (adr_lo_q),
        .ee_rdata (ee_rdata),
        .ee_paddr (pgm_addr[7:0]),
        .ee_pdata (ee_pdata),
        .fl_we    (pgm_req & pgm_we & pgm_space & ~prot),
        .fl_paddr (pgm_addr),
        .fl_wdata (pgm_wdata),
        .fl_pdata (fl_pdata),
        .fl_raddr ({adr_hi_q, adr_lo_q}),
        .fl_rdata (fl_rdata)
    );

    assign hrdata      = rdata_q;
    assign hreadyout   = ready_q;
    assign hresp       = 1'b0;
    assign pgm_rdata   = pgm_rdata_q;
    assign pgm_refused = pgm_refused_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_pgm_no_write: assert property (
        (ctl_we && wdat[efa_pkg::CTL_WR] && wdat[efa_pkg::CTL_SPACE] && !wr_busy)
        |=> !wr_busy) else $error("write started in program space");
    chk_permit_first: assert property (
        $rose(wr_busy) |-> $past(permit_q)) else $error("write without permit");
    chk_unlock_seq: assert property (
        $rose(wr_busy) |-> $past(ul_q) == efa_pkg::UL_ARMED)
        else $error("write without unlock sequence");
    chk_wr_not_cleared: assert property (
        (wr_busy && ctl_we && !wdat[efa_pkg::CTL_WR] && tmr_q > 32'h1 && !sreset)
        |=> wr_busy) else $error("software cleared a running write");
    chk_erase_byte: assert property (
        (st_q == efa_pkg::WR_ERASE && ee_we) |=> st_q == efa_pkg::WR_PROG)
        else $error("erase not followed by program");
    chk_ee_read_next: assert property (
        ($rose(rd_q) && !space_q && !sreset) |=> !rd_q && dat_lo_q == $past(ee_rdata))
        else $error("eeprom read not ready next cycle");
    chk_fl_read_two: assert property (
        ($rose(rd_q) && space_q) |-> ##1 (rd_q || $past(sreset)) ##1 !rd_q)
        else $error("flash read not two cycles");
    chk_abort_on_rst: assert property (
        (sreset && wr_busy) |=> abort_q && !wr_busy) else $error("abort flag missed");
    chk_rst_clears: assert property (
        sreset |=> dat_lo_q == 8'h00 && adr_lo_q == 8'h00 && !space_q)
        else $error("registers not cleared by reset");
    chk_done_flag: assert property (
        wr_end && !sreset |=> done_q && !wr_busy) else $error("done flag not set");
    chk_protect_refuse: assert property (
        (pgm_req && prot) |=> pgm_refused && pgm_rdata == 14'h0000)
        else $error("programmer not refused");
endmodule : efa_ctrl

//--- testbench/tb.sv
// Purpose: self-checking bench for the nonvolatile access controller
// Assumes: one AHB-Lite master, write timer shortened to 40 cycles
// Notes:   drivers queue expected values; a monitor pops and compares
`timescale 1ns/10ps
module tb;
    localparam int WC = 40;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        cprot = 1'b0;
    logic [2:0]  prq = 3'h0;
    logic        pgm_req = 1'b0;
    logic        pgm_we = 1'b0;
    logic        pgm_space = 1'b0;
    logic [12:0] pgm_addr = 13'h0;
    logic [13:0] pgm_wdata = 14'h0;
    logic [13:0] pgm_rdata;
    logic        pgm_refused;
    logic [31:0] eq[$];
    logic [31:0] mq[$];
    logic [14:0] pe[$];
    logic [31:0] rdv;
    logic        dp = 1'b0;
    logic        pq = 1'b0;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [13:0] fw;
    int          err_total = 0;
    int          total_checks = 0;

    always #20 hclk = ~hclk;

    efa_ctrl #(.WRITE_CYCLES(WC)) efa_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .code_protect(cprot), .ext_reset_req(prq[0]), .wdt_reset_req(prq[1]),
        .bor_req(prq[2]), .pgm_req(pgm_req), .pgm_we(pgm_we), .pgm_space(pgm_space),
        .pgm_addr(pgm_addr), .pgm_wdata(pgm_wdata), .pgm_rdata(pgm_rdata),
        .pgm_refused(pgm_refused));

    task finish_test;
        $display("err_total %0d total_checks %0d", err_total, total_checks);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    task fail(input string m);
        err_total++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail

    task cmp_bus(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        total_checks++;
        if ((g & m) !== (e & m)) fail("register read mismatch");
        // the slave has no error path, so every completed read must be okay
        if (hresp !== 1'b0) fail("bus response not okay");
    endtask : cmp_bus

    task cmp_pgm(input logic [14:0] g, input logic [14:0] e);
        total_checks++;
        if (g !== e) fail("programmer result mismatch");
    endtask : cmp_pgm

    // samples the value from before the edge, as the slave sees it
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail("bus wait timeout");
            finish_test;
        end
    endtask : wait_rdy

    task xfer(input logic w, input logic [7:0] ad, input logic [7:0] wd,
              input logic [7:0] e, input logic [31:0] m);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ad};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        if (!w) begin
            eq.push_back({24'h0, e});
            mq.push_back(m);
        end
        wait_rdy;
        rdv = hrdata;
        hsel <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] ad, input logic [7:0] wd);
        xfer(1'b1, ad, wd, 8'h0, 32'h0);
    endtask : wr

    task rd(input logic [7:0] ad, input logic [7:0] e);
        xfer(1'b0, ad, 8'h0, e, 32'hFFFFFFFF);
    endtask : rd

    task unlock;
        wr(efa_pkg::OFF_UNLOCK, efa_pkg::UNLOCK_KEY1);
        wr(efa_pkg::OFF_UNLOCK, efa_pkg::UNLOCK_KEY2);
    endtask : unlock

    task ee_write(input logic [7:0] ad, input logic [7:0] wd);
        wr(efa_pkg::OFF_ADR_LO, ad);
        wr(efa_pkg::OFF_DAT_LO, wd);
        wr(efa_pkg::OFF_CTL, 8'h04);
        unlock;
        wr(efa_pkg::OFF_CTL, 8'h06);
    endtask : ee_write

    task pgm(input logic sp, input logic we, input logic [12:0] ad,
             input logic [13:0] wd, input logic [14:0] e);
        @(posedge hclk);
        pgm_req   <= 1'b1;
        pgm_we    <= we;
        pgm_space <= sp;
        pgm_addr  <= ad;
        pgm_wdata <= wd;
        if (!we) pe.push_back(e);
        @(posedge hclk);
        pgm_req <= 1'b0;
        pgm_we  <= 1'b0;
        @(posedge hclk);
    endtask : pgm

    always @(posedge hclk) begin
        if (dp && hreadyout === 1'b1) cmp_bus(hrdata, eq.pop_front(), mq.pop_front());
        if (pq) cmp_pgm({pgm_refused, pgm_rdata}, pe.pop_front());
        dp <= (hsel && htrans[1] && hreadyout && !hwrite) ? 1'b1 : (hreadyout ? 1'b0 : dp);
        pq <= pgm_req && !pgm_we;
    end

    initial begin
        int n;
        void'($urandom(31474));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(i * 4), 8'h00);
        wr(efa_pkg::OFF_DAT_HI, 8'hFF);
        wr(efa_pkg::OFF_ADR_HI, 8'hFF);
        wr(efa_pkg::OFF_UNLOCK, 8'h3C);
        rd(efa_pkg::OFF_DAT_HI, 8'h3F);
        rd(efa_pkg::OFF_ADR_HI, 8'h1F);
        rd(efa_pkg::OFF_UNLOCK, 8'h00);
        unlock;
        wr(efa_pkg::OFF_CTL, 8'h06);
        rd(efa_pkg::OFF_CTL, 8'h04);
        wr(efa_pkg::OFF_CTL, 8'h06);
        rd(efa_pkg::OFF_CTL, 8'h04);
        wr(efa_pkg::OFF_CTL, 8'h84);
        unlock;
        wr(efa_pkg::OFF_CTL, 8'h86);
        rd(efa_pkg::OFF_CTL, 8'h84);
        a = 8'($urandom);
        d = 8'($urandom);
        ee_write(a, d);
        rd(efa_pkg::OFF_CTL, 8'h06);
        wr(efa_pkg::OFF_CTL, 8'h05);
        rd(efa_pkg::OFF_CTL, 8'h06);
        n = 0;
        // every poll must show permit only, apart from the busy bit itself
        do begin
            xfer(1'b0, efa_pkg::OFF_CTL, 8'h0, 8'h04, 32'hFFFF_FFFD);
            n++;
        end while (rdv[efa_pkg::CTL_WR] !== 1'b0 && n < 30);
        if (rdv[efa_pkg::CTL_WR] !== 1'b0) begin
            fail("write never finished");
            finish_test;
        end
        rd(efa_pkg::OFF_CTL, 8'h04);
        rd(efa_pkg::OFF_PFLAG, 8'h80);
        wr(efa_pkg::OFF_PFLAG, 8'h00);
        rd(efa_pkg::OFF_PFLAG, 8'h00);
        wr(efa_pkg::OFF_DAT_LO, ~d);
        wr(efa_pkg::OFF_CTL, 8'h05);
        repeat (2) @(posedge hclk);
        rd(efa_pkg::OFF_DAT_LO, d);
        fw = 14'($urandom);
        pgm(1'b1, 1'b1, 13'h1FFF, fw, 15'h0);
        wr(efa_pkg::OFF_ADR_HI, 8'h1F);
        wr(efa_pkg::OFF_ADR_LO, 8'hFF);
        wr(efa_pkg::OFF_CTL, 8'h81);
        repeat (3) @(posedge hclk);
        rd(efa_pkg::OFF_DAT_LO, fw[7:0]);
        rd(efa_pkg::OFF_DAT_HI, {2'h0, fw[13:8]});
        cprot <= 1'b1;
        repeat (3) @(posedge hclk);
        pgm(1'b0, 1'b0, {5'h0, a}, 14'h0, {1'b1, 14'h0});
        wr(efa_pkg::OFF_ADR_LO, a);
        wr(efa_pkg::OFF_CTL, 8'h01);
        repeat (2) @(posedge hclk);
        rd(efa_pkg::OFF_DAT_LO, d);
        cprot <= 1'b0;
        repeat (3) @(posedge hclk);
        pgm(1'b0, 1'b0, {5'h0, a}, 14'h0, {7'h0, d});
        // each pin reset source in turn cuts a running write short
        for (int s = 0; s < 3; s++) begin
            ee_write(a + 8'h01, d);
            prq[s] <= 1'b1;
            repeat (4) @(posedge hclk);
            prq[s] <= 1'b0;
            repeat (3) @(posedge hclk);
            rd(efa_pkg::OFF_CTL, 8'h08);
            rd(efa_pkg::OFF_ADR_LO, 8'h00);
            rd(efa_pkg::OFF_DAT_LO, 8'h00);
        end
        finish_test;
    end
endmodule : tb
